/* File: hdl/esrp_host.sv */
// Two-wire host controller for the environment sensor, AXI4-Lite controlled
`timescale 1ns/1ps
module esrp_host #(
    parameter int GUARD_CYCLES   = esrp_pkg::GUARD_CYC,
    parameter int QUARTER_CYCLES = esrp_pkg::QUARTER_CYC
) (
    input  wire logic                    sys_clk_in,
    input  wire logic                    reset_in,
    input  wire logic                    ce_in,
    input  wire logic                    ready_n_in,
    input  wire logic                    scl_in,
    input  wire logic                    sda_in,
    input  wire esrp_pkg::esrp_axi_req_t axi_in,
    output esrp_pkg::esrp_axi_rsp_t      axi_out,
    output logic                         scl_out,
    output logic                         scl_oe_out,
    output logic                         sda_out,
    output logic                         sda_oe_out
);
    if (GUARD_CYCLES < 1 || QUARTER_CYCLES < 2 || QUARTER_CYCLES > 65535) begin : g_bad
        $error("esrp_host: unsupported timing parameters");
    end

    esrp_pkg::esrp_regs_t r_q;
    esrp_pkg::esrp_regs_t r_d;
    logic                 adv;
    logic                 rd;
    logic                 last;
    logic                 busy;
    logic [6:0]           dev;

    function automatic logic cmd_ok(input logic [1:0] op, input logic [2:0] len,
                                    input logic [7:0] ra);
        cmd_ok = (op == esrp_pkg::OP_CMD) ||
                 ((op == esrp_pkg::OP_WR || op == esrp_pkg::OP_RD) && len != 3'h0 &&
                  len <= esrp_pkg::MAX_LEN &&
                  !(op == esrp_pkg::OP_WR && ra == esrp_pkg::REG_SOUND_THR &&
                    len != esrp_pkg::SOUND_THR_LEN));
    endfunction

    function automatic logic [7:0] pick(input logic [31:0] w, input logic [1:0] i);
        pick = w[{i, 3'b000} +: 8];
    endfunction

    assign rd   = r_q.phase == esrp_pkg::PH_RDATA;
    assign last = r_q.byte_n == 2'(r_q.len - 3'h1);
    assign busy = r_q.pend || r_q.state != esrp_pkg::ST_IDLE;
    assign dev  = r_q.alt ? esrp_pkg::DEV_ADDR_ALT : esrp_pkg::DEV_ADDR;

    always_comb begin
        r_d = r_q;
        adv = 1'b0;
        r_d.rdy_s1 = ready_n_in;
        r_d.rdy_s2 = r_q.rdy_s1;
        r_d.sda_s1 = sda_in;
        r_d.sda_s2 = r_q.sda_s1;
        r_d.scl_s1 = scl_in;
        r_d.scl_s2 = r_q.scl_s1;
        if (r_q.guard != 32'h0) begin
            r_d.guard = r_q.guard - 32'h1;
        end
        // Register slave
        if (axi_in.awvalid && r_q.rsp.awready) begin
            r_d.aw_have = 1'b1;
            r_d.awaddr  = axi_in.awaddr;
        end
        if (axi_in.wvalid && r_q.rsp.wready) begin
            r_d.w_have = 1'b1;
            r_d.wdata  = axi_in.wdata;
            r_d.wstrb  = axi_in.wstrb;
        end
        if (axi_in.bready && r_q.rsp.bvalid) begin
            r_d.rsp.bvalid = 1'b0;
        end
        if (r_q.aw_have && r_q.w_have && !r_q.rsp.bvalid) begin
            r_d.aw_have    = 1'b0;
            r_d.w_have     = 1'b0;
            r_d.rsp.bvalid = 1'b1;
            r_d.rsp.bresp  = esrp_pkg::RESP_OKAY;
            case (r_q.awaddr)
                esrp_pkg::A_CTRL: begin
                    if (r_q.wstrb[0]) begin
                        r_d.alt = r_q.wdata[0];
                    end
                end
                esrp_pkg::A_CMD: begin
                    if (busy || !cmd_ok(r_q.wdata[esrp_pkg::CMD_OP_LSB +: 2],
                                        r_q.wdata[esrp_pkg::CMD_LEN_LSB +: 3],
                                        r_q.wdata[7:0])) begin
                        r_d.refused = 1'b1;
                    end else begin
                        r_d.pend  = 1'b1;
                        r_d.op    = r_q.wdata[esrp_pkg::CMD_OP_LSB +: 2];
                        r_d.len   = r_q.wdata[esrp_pkg::CMD_LEN_LSB +: 3];
                        r_d.reg_a = r_q.wdata[7:0];
                    end
                end
                esrp_pkg::A_TXDATA: begin
                    for (int i = 0; i < 4; i++) begin
                        if (r_q.wstrb[i]) begin
                            r_d.tx[i*8 +: 8] = r_q.wdata[i*8 +: 8];
                        end
                    end
                end
                esrp_pkg::A_STATUS: begin
                    if (r_q.wdata[esrp_pkg::SB_NACK]) begin
                        r_d.nack = 1'b0;
                    end
                    if (r_q.wdata[esrp_pkg::SB_REFUSED]) begin
                        r_d.refused = 1'b0;
                    end
                end
                esrp_pkg::A_RXDATA: begin
                end
                default: begin
                    r_d.rsp.bresp = esrp_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (axi_in.rready && r_q.rsp.rvalid) begin
            r_d.rsp.rvalid = 1'b0;
        end
        if (axi_in.arvalid && r_q.rsp.arready) begin
            r_d.rsp.rvalid = 1'b1;
            r_d.rsp.rresp  = esrp_pkg::RESP_OKAY;
            r_d.rsp.rdata  = 32'h0;
            case (axi_in.araddr)
                esrp_pkg::A_CTRL:   r_d.rsp.rdata[0] = r_q.alt;
                esrp_pkg::A_TXDATA: r_d.rsp.rdata = r_q.tx;
                esrp_pkg::A_RXDATA: r_d.rsp.rdata = r_q.rx;
                esrp_pkg::A_CMD: begin
                    r_d.rsp.rdata[7:0] = r_q.reg_a;
                    r_d.rsp.rdata[esrp_pkg::CMD_LEN_LSB +: 3] = r_q.len;
                    r_d.rsp.rdata[esrp_pkg::CMD_OP_LSB +: 2]  = r_q.op;
                end
                esrp_pkg::A_STATUS: begin
                    r_d.rsp.rdata[esrp_pkg::SB_BUSY]    = busy;
                    r_d.rsp.rdata[esrp_pkg::SB_NACK]    = r_q.nack;
                    r_d.rsp.rdata[esrp_pkg::SB_READY]   = !r_q.rdy_s2;
                    r_d.rsp.rdata[esrp_pkg::SB_GUARD]   = r_q.guard != 32'h0;
                    r_d.rsp.rdata[esrp_pkg::SB_REFUSED] = r_q.refused;
                    r_d.rsp.rdata[esrp_pkg::SB_SCL]     = r_q.scl_s2;
                end
                default: r_d.rsp.rresp = esrp_pkg::RESP_SLVERR;
            endcase
        end
        // Bus engine; its flag sets come after the software clears so they win
        if (r_q.state == esrp_pkg::ST_IDLE) begin
            if (r_q.pend && !r_q.rdy_s2 && r_q.guard == 32'h0) begin
                r_d.state  = esrp_pkg::ST_START;
                r_d.pend   = 1'b0;
                r_d.q      = 2'h0;
                r_d.tick   = 16'(QUARTER_CYCLES - 1);
                r_d.bit_n  = 4'h0;
                r_d.byte_n = 2'h0;
                r_d.phase  = esrp_pkg::PH_ADDR_W;
            end
        end else if (r_q.tick != 16'h0) begin
            r_d.tick = r_q.tick - 16'h1;
        end else begin
            adv    = 1'b1;
            r_d.tick = 16'(QUARTER_CYCLES - 1);
            r_d.q    = r_q.q + 2'h1;
            case (r_q.state)
                esrp_pkg::ST_START: begin
                    case (r_q.q)
                        2'h0: r_d.sda_oe = 1'b1;
                        2'h1: r_d.scl_oe = 1'b1;
                        2'h3: begin
                            r_d.state = esrp_pkg::ST_BIT;
                            r_d.sh    = {dev, 1'b0};
                        end
                        default: ;
                    endcase
                end
                esrp_pkg::ST_RESTART: begin
                    case (r_q.q)
                        2'h0: r_d.sda_oe = 1'b0;
                        2'h1: r_d.scl_oe = 1'b0;
                        2'h2: r_d.sda_oe = 1'b1;
                        default: begin
                            r_d.scl_oe = 1'b1;
                            r_d.state  = esrp_pkg::ST_BIT;
                            r_d.sh     = {dev, 1'b1};
                            r_d.phase  = esrp_pkg::PH_ADDR_R;
                        end
                    endcase
                end
                esrp_pkg::ST_STOP: begin
                    case (r_q.q)
                        2'h0: r_d.sda_oe = 1'b1;
                        2'h1: r_d.scl_oe = 1'b0;
                        2'h2: r_d.sda_oe = 1'b0;
                        default: begin
                            r_d.state = esrp_pkg::ST_IDLE;
                            if (r_q.op != esrp_pkg::OP_RD) begin
                                r_d.guard = 32'(GUARD_CYCLES);
                            end
                        end
                    endcase
                end
                esrp_pkg::ST_BIT: begin
                    case (r_q.q)
                        2'h0: begin
                            if (r_q.bit_n < 4'h8) begin
                                r_d.sda_oe = !rd && !r_q.sh[7];
                            end else begin
                                r_d.sda_oe = rd && !last;
                            end
                        end
                        2'h1: r_d.scl_oe = 1'b0;
                        2'h2: begin
                            if (r_q.bit_n == 4'h8) begin
                                r_d.ackn = r_q.sda_s2;
                            end else if (rd) begin
                                r_d.sh = {r_q.sh[6:0], r_q.sda_s2};
                            end
                        end
                        default: begin
                            r_d.scl_oe = 1'b1;
                            if (r_q.bit_n < 4'h8) begin
                                r_d.bit_n = r_q.bit_n + 4'h1;
                                if (!rd) begin
                                    r_d.sh = {r_q.sh[6:0], 1'b0};
                                end
                            end else begin
                                r_d.bit_n = 4'h0;
                                if (!rd && r_q.ackn) begin
                                    r_d.nack  = 1'b1;
                                    r_d.state = esrp_pkg::ST_STOP;
                                end else begin
                                    case (r_q.phase)
                                        esrp_pkg::PH_ADDR_W: begin
                                            r_d.phase = esrp_pkg::PH_REG;
                                            r_d.sh    = r_q.reg_a;
                                        end
                                        esrp_pkg::PH_REG: begin
                                            if (r_q.op == esrp_pkg::OP_WR) begin
                                                r_d.phase = esrp_pkg::PH_WDATA;
                                                r_d.sh    = pick(r_q.tx, 2'h0);
                                            end else if (r_q.op == esrp_pkg::OP_RD) begin
                                                r_d.state = esrp_pkg::ST_RESTART;
                                            end else begin
                                                r_d.state = esrp_pkg::ST_STOP;
                                            end
                                        end
                                        esrp_pkg::PH_WDATA: begin
                                            if (last) begin
                                                r_d.state = esrp_pkg::ST_STOP;
                                            end else begin
                                                r_d.byte_n = r_q.byte_n + 2'h1;
                                                r_d.sh     = pick(r_q.tx, r_q.byte_n + 2'h1);
                                            end
                                        end
                                        esrp_pkg::PH_ADDR_R: begin
                                            r_d.phase = esrp_pkg::PH_RDATA;
                                        end
                                        default: begin
                                            r_d.rx[{r_q.byte_n, 3'b000} +: 8] = r_q.sh;
                                            if (last) begin
                                                r_d.state = esrp_pkg::ST_STOP;
                                            end else begin
                                                r_d.byte_n = r_q.byte_n + 2'h1;
                                            end
                                        end
                                    endcase
                                end
                            end
                        end
                    endcase
                end
                default: r_d.state = esrp_pkg::ST_IDLE;
            endcase
        end
        r_d.rsp.awready = !r_d.aw_have;
        r_d.rsp.wready  = !r_d.w_have;
        r_d.rsp.arready = !r_d.rsp.rvalid;
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            r_q <= esrp_pkg::REGS_RST;
        end else if (ce_in) begin
            r_q <= r_d;
        end
    end

    // Open-drain pins: only ever pulled low
    assign axi_out    = r_q.rsp;
    assign scl_out    = 1'b0;
    assign sda_out    = 1'b0;
    assign scl_oe_out = r_q.scl_oe;
    assign sda_oe_out = r_q.sda_oe;

    property p_start_ready;
        @(posedge sys_clk_in) disable iff (reset_in)
        (ce_in && r_q.state == esrp_pkg::ST_IDLE && r_d.state == esrp_pkg::ST_START)
            |-> !r_q.rdy_s2;
    endproperty
    a_start_ready: assert property (p_start_ready) else $error("start while not ready");

    property p_start_guard;
        @(posedge sys_clk_in) disable iff (reset_in)
        (ce_in && r_q.state == esrp_pkg::ST_IDLE && r_d.state == esrp_pkg::ST_START)
            |-> r_q.guard == 32'h0;
    endproperty
    a_start_guard: assert property (p_start_guard) else $error("start inside guard");

    property p_guard_load;
        @(posedge sys_clk_in) disable iff (reset_in)
        (ce_in && r_q.state == esrp_pkg::ST_STOP && r_d.state == esrp_pkg::ST_IDLE &&
         r_q.op != esrp_pkg::OP_RD) |=> r_q.guard == 32'(GUARD_CYCLES);
    endproperty
    a_guard_load: assert property (p_guard_load) else $error("guard not loaded");

    property p_first_byte;
        @(posedge sys_clk_in) disable iff (reset_in)
        (r_q.state == esrp_pkg::ST_BIT && r_q.phase == esrp_pkg::PH_ADDR_W &&
         r_q.bit_n == 4'h0) |-> r_q.sh == {dev, 1'b0};
    endproperty
    a_first_byte: assert property (p_first_byte) else $error("bad first byte");

    property p_cmd_stop;
        @(posedge sys_clk_in) disable iff (reset_in)
        (ce_in && adv && r_q.state == esrp_pkg::ST_BIT && r_q.q == 2'h3 &&
         r_q.bit_n == 4'h8 && r_q.phase == esrp_pkg::PH_REG && r_q.op == esrp_pkg::OP_CMD)
            |=> r_q.state == esrp_pkg::ST_STOP;
    endproperty
    a_cmd_stop: assert property (p_cmd_stop) else $error("data after command");

    property p_msb_first;
        @(posedge sys_clk_in) disable iff (reset_in)
        (ce_in && adv && r_q.state == esrp_pkg::ST_BIT && r_q.q == 2'h3 && !rd &&
         r_q.bit_n < 4'h8) |=> r_q.sh == {$past(r_q.sh[6:0]), 1'b0};
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("bit order");

    property p_lsb_first;
        @(posedge sys_clk_in) disable iff (reset_in)
        (r_q.state == esrp_pkg::ST_BIT && r_q.phase == esrp_pkg::PH_WDATA &&
         r_q.bit_n == 4'h0) |-> r_q.sh == pick(r_q.tx, r_q.byte_n);
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("byte order");

    property p_last_nack;
        @(posedge sys_clk_in) disable iff (reset_in)
        (r_q.state == esrp_pkg::ST_BIT && rd && last && r_q.bit_n == 4'h8) |-> !r_q.sda_oe;
    endproperty
    a_last_nack: assert property (p_last_nack) else $error("last read byte acked");

    property p_sound_len;
        @(posedge sys_clk_in) disable iff (reset_in)
        (ce_in && r_d.pend && !r_q.pend && r_d.op == esrp_pkg::OP_WR &&
         r_d.reg_a == esrp_pkg::REG_SOUND_THR) |=> r_q.len == esrp_pkg::SOUND_THR_LEN;
    endproperty
    a_sound_len: assert property (p_sound_len) else $error("short threshold");

    property p_restart_read;
        @(posedge sys_clk_in) disable iff (reset_in)
        r_q.state == esrp_pkg::ST_RESTART |-> r_q.op == esrp_pkg::OP_RD;
    endproperty
    a_restart_read: assert property (p_restart_read) else $error("restart not read");

    c_cmd_done: cover property (@(posedge sys_clk_in) disable iff (reset_in)
        r_q.state == esrp_pkg::ST_STOP && r_q.op == esrp_pkg::OP_CMD && !r_q.nack);
    c_wr_done: cover property (@(posedge sys_clk_in) disable iff (reset_in)
        r_q.state == esrp_pkg::ST_STOP && r_q.phase == esrp_pkg::PH_WDATA);
    c_rd_done: cover property (@(posedge sys_clk_in) disable iff (reset_in)
        r_q.state == esrp_pkg::ST_STOP && r_q.phase == esrp_pkg::PH_RDATA);
endmodule // esrp_host

/* File: pkg/esrp_pkg.sv */
// Package of constants and types for the sensor two-wire host controller
package esrp_pkg;
    localparam int SYS_PERIOD_NS  = 4;
    localparam int SCL_QUARTER_NS = 2500;
    localparam int QUARTER_CYC    = (SCL_QUARTER_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int GUARD_MS       = 6;
    localparam int GUARD_CYC      = (GUARD_MS * 1000000 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

    localparam logic [6:0] DEV_ADDR      = 7'h71;
    localparam logic [6:0] DEV_ADDR_ALT  = 7'h70;
    localparam logic [7:0] REG_SOUND_THR = 8'h86;
    localparam logic [7:0] REG_CYCLE_PER = 8'h89;
    localparam logic [7:0] REG_MEAS_NOW  = 8'he1;
    localparam logic [2:0] SOUND_THR_LEN = 3'h2;
    localparam logic [2:0] MAX_LEN       = 3'h4;

    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_CMD    = 8'h04;
    localparam logic [7:0] A_TXDATA = 8'h08;
    localparam logic [7:0] A_RXDATA = 8'h0c;
    localparam logic [7:0] A_STATUS = 8'h10;

    localparam int CMD_LEN_LSB = 8;
    localparam int CMD_OP_LSB  = 12;
    localparam int SB_BUSY     = 0;
    localparam int SB_NACK     = 1;
    localparam int SB_READY    = 2;
    localparam int SB_GUARD    = 3;
    localparam int SB_REFUSED  = 4;
    localparam int SB_SCL      = 5;

    localparam logic [1:0] OP_CMD = 2'h0;
    localparam logic [1:0] OP_WR  = 2'h1;
    localparam logic [1:0] OP_RD  = 2'h2;
    localparam logic [2:0] PH_ADDR_W = 3'h0;
    localparam logic [2:0] PH_REG    = 3'h1;
    localparam logic [2:0] PH_WDATA  = 3'h2;
    localparam logic [2:0] PH_ADDR_R = 3'h3;
    localparam logic [2:0] PH_RDATA  = 3'h4;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_BIT, ST_RESTART, ST_STOP} esrp_fsm_t;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } esrp_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } esrp_axi_rsp_t;

    typedef struct packed {
        esrp_fsm_t     state;
        logic [1:0]    q;
        logic [15:0]   tick;
        logic [3:0]    bit_n;
        logic [1:0]    byte_n;
        logic [2:0]    phase;
        logic [7:0]    sh;
        logic          ackn;
        logic [1:0]    op;
        logic [7:0]    reg_a;
        logic [2:0]    len;
        logic          pend;
        logic          alt;
        logic [31:0]   tx;
        logic [31:0]   rx;
        logic          nack;
        logic          refused;
        logic [31:0]   guard;
        logic          rdy_s1;
        logic          rdy_s2;
        logic          sda_s1;
        logic          sda_s2;
        logic          scl_s1;
        logic          scl_s2;
        logic          scl_oe;
        logic          sda_oe;
        logic          aw_have;
        logic [7:0]    awaddr;
        logic          w_have;
        logic [31:0]   wdata;
        logic [3:0]    wstrb;
        esrp_axi_rsp_t rsp;
    } esrp_regs_t;

    localparam esrp_regs_t REGS_RST = '0;
endpackage

/* File: tb/esrp_dev_model.sv */
// Behavioural model of the sensor's two-wire target port
`timescale 1ns/1ps
module esrp_dev_model (
    input  wire logic scl_in,
    input  wire logic sda_in,
    input  wire logic strap_in,
    output logic      sda_oe_out,
    output logic      ready_n_out
);
    logic [7:0] sh, ptr, mem [256];
    int         n = 0, st = 0;
    initial begin sda_oe_out = 0; ready_n_out = 0; end
    always @(negedge sda_in) if (scl_in) begin n = 0; st = 1; end
    always @(posedge sda_in) if (scl_in) begin
        if (st == 3 && ptr == 8'he1) begin ready_n_out = 1; ready_n_out <= #4000 0; end
        st = 0;
    end
    always @(posedge scl_in) begin
        sh = {sh[6:0], sda_in};
        n++;
        if (n == 9 && st == 4 && sda_in) st = 0;
    end
    always @(negedge scl_in) begin
        sda_oe_out = 0;
        if (n == 9) begin n = 0; if (st == 4) begin sh = ptr == 8'he1 ? 8'hff : mem[ptr]; ptr++; end end
        if (n == 8) case (st)
            1: begin sda_oe_out = sh[7:1] == {6'h38, !strap_in} && !ready_n_out;
                st = !sda_oe_out ? 0 : sh[0] ? 4 : 2; end
            2: begin ptr = sh; st = 3; sda_oe_out = 1; end
            3: begin sda_oe_out = ptr != 8'he1; if (sda_oe_out) begin mem[ptr] = sh; ptr++; end end
        endcase else if (st == 4) sda_oe_out = !sh[7];
    end
endmodule // esrp_dev_model

/* File: tb/esrp_host_test.sv */
// Self-checking testbench of the two-wire host controller
`timescale 1ns/1ps
module esrp_host_test;
    logic                    clk = 0, rst = 1, strap = 0;
    logic [31:0]             seed = 32'd93737, s;
    logic [1:0]              rr;
    logic [7:0]              em [256];
    int                      n_mismatch = 0, n_compared = 0;
    esrp_pkg::esrp_axi_req_t req = '0;
    esrp_pkg::esrp_axi_rsp_t rsp;
    wire                     scl_oe, sda_oe, dev_oe, rdy_n;
    wire                     scl = !scl_oe;
    wire                     sda = !sda_oe && !dev_oe;
    esrp_host #(.GUARD_CYCLES(200), .QUARTER_CYCLES(8)) i_esrp_host (.sys_clk_in(clk),
        .reset_in(rst), .ce_in(1'b1), .ready_n_in(rdy_n), .scl_in(scl), .sda_in(sda),
        .axi_in(req), .axi_out(rsp), .scl_out(), .scl_oe_out(scl_oe), .sda_out(),
        .sda_oe_out(sda_oe));
    esrp_dev_model i_esrp_dev_model (.scl_in(scl), .sda_in(sda), .strap_in(strap),
        .sda_oe_out(dev_oe), .ready_n_out(rdy_n));
    initial forever #2 clk = !clk;
    initial begin repeat (90000) @(posedge clk); n_mismatch++; final_report; end
    function automatic logic [15:0] lf();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[15:0];
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
        n_compared++;
        if (v !== e) begin n_mismatch++; $display("mismatch %s exp %h seen %h", nm, e, v); end
    endtask
    // Each channel is released once, at its own handshake; an idle edge follows the response
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic aw_on, w_on, b_on;
        aw_on = 1'b1; w_on = 1'b1; b_on = 1'b1;
        req.awvalid <= 1; req.wvalid <= 1; req.awaddr <= a; req.wdata <= d;
        req.wstrb <= 4'hf; req.bready <= 1;
        while (b_on) begin
            @(posedge clk);
            if (aw_on && rsp.awready) begin aw_on = 1'b0; req.awvalid <= 0; end
            if (w_on && rsp.wready) begin w_on = 1'b0; req.wvalid <= 0; end
            if (rsp.bvalid) begin b_on = 1'b0; req.bready <= 0; end
        end
        @(posedge clk);
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_on, r_on;
        ar_on = 1'b1; r_on = 1'b1;
        req.arvalid <= 1; req.araddr <= a; req.rready <= 1;
        while (r_on) begin
            @(posedge clk);
            if (ar_on && rsp.arready) begin ar_on = 1'b0; req.arvalid <= 0; end
            if (rsp.rvalid) begin r_on = 1'b0; req.rready <= 0; d = rsp.rdata; r = rsp.rresp; end
        end
        @(posedge clk);
    endtask
    task automatic go(input logic [1:0] op, input logic [2:0] ln, input logic [7:0] ra);
        axw(esrp_pkg::A_CMD, {18'h0, op, 1'b0, ln, ra});
        for (int i = 0; i < 3000; i++) begin
            axr(esrp_pkg::A_STATUS, s, rr);
            if (s[0] === 1'b0 && s[3] === 1'b0) break;
        end
        chk("idle", 32'h0, {30'h0, s[3], s[0]});
    endtask
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        logic [15:0] v;
        repeat (8) @(posedge clk);
        rst <= 0;
        repeat (2) @(posedge clk);
        axr(esrp_pkg::A_STATUS, s, rr);
        chk("status", 32'h24, s);
        repeat (2) begin
            v = lf();
            axw(esrp_pkg::A_TXDATA, {16'h0, v});
            go(esrp_pkg::OP_WR, 3'h2, 8'h86);
            em[8'h86] = v[7:0];
            em[8'h87] = v[15:8];
            chk("thr", {em[8'h87], em[8'h86]}, {i_esrp_dev_model.mem[8'h87], i_esrp_dev_model.mem[8'h86]});
            chk("thr_lo", em[8'h86], i_esrp_dev_model.mem[8'h86]);
            go(esrp_pkg::OP_RD, 3'h2, 8'h86);
            axr(esrp_pkg::A_RXDATA, s, rr);
            chk("rx_thr", {em[8'h87], em[8'h86]}, s);
        end
        $display("test threshold done");
        strap <= 1;
        axw(esrp_pkg::A_CTRL, 32'h1);
        v = lf();
        axw(esrp_pkg::A_TXDATA, {16'h0, v});
        go(esrp_pkg::OP_WR, 3'h1, 8'h89);
        em[8'h89] = v[7:0];
        chk("cyc", em[8'h89], i_esrp_dev_model.mem[8'h89]);
        strap <= 0;
        go(esrp_pkg::OP_WR, 3'h1, 8'h89);
        axr(esrp_pkg::A_STATUS, s, rr);
        chk("nack", 1, s[1]);
        axw(esrp_pkg::A_STATUS, 32'h12);
        axw(esrp_pkg::A_CTRL, 32'h0);
        go(esrp_pkg::OP_WR, 3'h1, 8'h86);
        axr(esrp_pkg::A_STATUS, s, rr);
        chk("refused", 1, s[4]);
        chk("thr_kept", em[8'h86], i_esrp_dev_model.mem[8'h86]);
        $display("test address done");
        go(esrp_pkg::OP_CMD, 3'h1, 8'he1);
        axr(esrp_pkg::A_STATUS, s, rr);
        chk("ready", 0, s[2]);
        go(esrp_pkg::OP_RD, 3'h1, 8'h89);
        axr(esrp_pkg::A_RXDATA, s, rr);
        // A one-byte read leaves the upper receive byte of the last threshold read in place
        chk("rx_cyc", {16'h0, em[8'h87], em[8'h89]}, s);
        axr(8'h20, s, rr);
        chk("slverr", esrp_pkg::RESP_SLVERR, rr);
        $display("test command done");
        final_report;
    end
endmodule // esrp_host_test
